// ===== fbpc_host.sv
/*
 * Host controller for the block-protection command sets of a parallel NOR
 * flash: software orders operations over AXI4-Lite, the block plays them out
 * as flash bus cycles. Assumes a 16-bit word-mode part and one clock domain.
 */
module fbpc_host (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [fbpc_pkg::ADDR_W-1:0] flashAddr,
  output logic [fbpc_pkg::DATA_W-1:0] flashDqOut,
  input wire logic [fbpc_pkg::DATA_W-1:0] flashDqIn,
  output logic flashDqOe,
  output logic chipSelectN,
  output logic outputEnableN,
  output logic writeEnableN,
  output logic writeProtectN
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_ISSUE = 2'b01, ST_WAIT = 2'b10, ST_GAP = 2'b11
  } fbpc_state_t;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) res[8*b +: 8] = nw[8*b +: 8];
    end
    return res;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= fbpc_pkg::REG_WPCTL);
  endfunction

  function automatic logic [fbpc_pkg::STEP_W-1:0] wr(input logic [fbpc_pkg::ADDR_W-1:0] a,
                                                    input logic [fbpc_pkg::DATA_W-1:0] d);
    return {1'b0, a, d};
  endfunction

  function automatic logic legal(input fbpc_pkg::fbpc_op_t op, input fbpc_pkg::fbpc_mode_t md);
    case (op)
      fbpc_pkg::OP_ENT_LOCK, fbpc_pkg::OP_ENT_PWD, fbpc_pkg::OP_ENT_NV,
      fbpc_pkg::OP_ENT_LKB, fbpc_pkg::OP_ENT_VOL, fbpc_pkg::OP_ENT_EXT:
        return md == fbpc_pkg::MD_NONE;
      fbpc_pkg::OP_EXIT, fbpc_pkg::OP_PROG: return md != fbpc_pkg::MD_NONE;
      fbpc_pkg::OP_READ: return 1'b1;
      fbpc_pkg::OP_CLR_NV: return md == fbpc_pkg::MD_NV;
      fbpc_pkg::OP_PWD_PROG, fbpc_pkg::OP_PWD_READ, fbpc_pkg::OP_PWD_UNLOCK:
        return md == fbpc_pkg::MD_PWD;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [3:0] countOf(input fbpc_pkg::fbpc_op_t op, input logic ext);
    case (op)
      fbpc_pkg::OP_ENT_LOCK, fbpc_pkg::OP_ENT_PWD, fbpc_pkg::OP_ENT_NV,
      fbpc_pkg::OP_ENT_LKB, fbpc_pkg::OP_ENT_VOL, fbpc_pkg::OP_ENT_EXT: return 4'h3;
      fbpc_pkg::OP_EXIT: return ext ? 4'h4 : 4'h2;
      fbpc_pkg::OP_PROG, fbpc_pkg::OP_CLR_NV: return 4'h2;
      fbpc_pkg::OP_PWD_PROG: return 4'h8;
      fbpc_pkg::OP_PWD_READ: return 4'h4;
      fbpc_pkg::OP_PWD_UNLOCK: return 4'h6;
      default: return 4'h1;
    endcase
  endfunction

  function automatic logic [fbpc_pkg::STEP_W-1:0] stepOf(input fbpc_pkg::fbpc_op_t op,
      input logic [2:0] i, input logic [fbpc_pkg::ADDR_W-1:0] a,
      input logic [fbpc_pkg::DATA_W-1:0] d, input logic [63:0] pw, input logic ext);
    logic [15:0] code;
    logic [1:0] p;
    logic [2:0] j;
    code = (op == fbpc_pkg::OP_ENT_LOCK) ? fbpc_pkg::CODE_LOCKREG :
           (op == fbpc_pkg::OP_ENT_PWD) ? fbpc_pkg::CODE_PWD :
           (op == fbpc_pkg::OP_ENT_NV) ? fbpc_pkg::CODE_NV :
           (op == fbpc_pkg::OP_ENT_LKB) ? fbpc_pkg::CODE_LKB :
           (op == fbpc_pkg::OP_ENT_VOL) ? fbpc_pkg::CODE_VOL : fbpc_pkg::CODE_EXT;
    j = i - 3'h2;
    case (op)
      fbpc_pkg::OP_ENT_LOCK, fbpc_pkg::OP_ENT_PWD, fbpc_pkg::OP_ENT_NV,
      fbpc_pkg::OP_ENT_LKB, fbpc_pkg::OP_ENT_VOL, fbpc_pkg::OP_ENT_EXT:
        return (i == 3'h0) ? wr(fbpc_pkg::ADDR_UNLK1, fbpc_pkg::CMD_UNLK1) :
               (i == 3'h1) ? wr(fbpc_pkg::ADDR_UNLK2, fbpc_pkg::CMD_UNLK2) :
               wr(fbpc_pkg::ADDR_UNLK1, code);
      fbpc_pkg::OP_EXIT: begin
        // Extended mode exit needs the unlock pair first
        if (ext && i == 3'h0) return wr(fbpc_pkg::ADDR_UNLK1, fbpc_pkg::CMD_UNLK1);
        if (ext && i == 3'h1) return wr(fbpc_pkg::ADDR_UNLK2, fbpc_pkg::CMD_UNLK2);
        p = ext ? j[1:0] : i[1:0];
        return (p == 2'h0) ? wr(fbpc_pkg::ADDR_UNLK1, fbpc_pkg::CODE_EXIT1) :
               wr(fbpc_pkg::ADDR_ANY, fbpc_pkg::CODE_EXIT2);
      end
      fbpc_pkg::OP_PROG:
        return (i == 3'h0) ? wr(fbpc_pkg::ADDR_ANY, fbpc_pkg::CODE_PROG) : wr(a, d);
      fbpc_pkg::OP_READ: return {1'b1, a, 16'h0000};
      fbpc_pkg::OP_CLR_NV:
        return (i == 3'h0) ? wr(fbpc_pkg::ADDR_ANY, fbpc_pkg::CODE_CLR1) :
               wr(fbpc_pkg::ADDR_ANY, fbpc_pkg::CODE_CLR2);
      fbpc_pkg::OP_PWD_PROG: begin
        p = i[2:1];
        return i[0] ? wr({fbpc_pkg::PWD_BASE[22:2], p}, pw[16*p +: 16]) :
               wr(fbpc_pkg::ADDR_ANY, fbpc_pkg::CODE_PROG);
      end
      fbpc_pkg::OP_PWD_READ: return {1'b1, fbpc_pkg::PWD_BASE[22:2], i[1:0], 16'h0000};
      fbpc_pkg::OP_PWD_UNLOCK: begin
        p = j[1:0];
        return (i == 3'h0) ? wr(fbpc_pkg::ADDR_ANY, fbpc_pkg::CODE_UNLOCK1) :
               (i == 3'h1) ? wr(fbpc_pkg::ADDR_ANY, fbpc_pkg::CODE_UNLOCK2) :
               wr({fbpc_pkg::PWD_BASE[22:2], p}, pw[16*p +: 16]);
      end
      default: return {fbpc_pkg::STEP_W{1'b0}};
    endcase
  endfunction

  fbpc_state_t state_r;
  fbpc_pkg::fbpc_op_t op_r;
  fbpc_pkg::fbpc_mode_t mode_r;
  logic [fbpc_pkg::STEP_W-1:0] steps_r [fbpc_pkg::MAX_STEPS];
  logic [3:0] idx_r, nSteps_r;
  logic [7:0] gapCnt_r;
  logic err_r;
  logic [fbpc_pkg::ADDR_W-1:0] tgtAddr_r;
  logic [63:0] pwd_r, pwdRead_r;
  logic [15:0] rdData_r;
  logic awHeld_r, wHeld_r;
  logic [7:0] awAddr_r;
  logic [31:0] wData_r;
  logic [3:0] wStrb_r;
  logic cycDone;
  logic [15:0] cycData;

  // Write channel: address and data taken in either order
  wire awTake = awvalid && awready;
  wire wTake = wvalid && wready;
  wire awHave = awHeld_r || awTake;
  wire wHave = wHeld_r || wTake;
  wire doWrite = awHave && wHave && !bvalid;
  wire [7:0] wrAddr = awHeld_r ? awAddr_r : awaddr;
  wire [31:0] wrData = wHeld_r ? wData_r : wdata;
  wire [3:0] wrStrb = wHeld_r ? wStrb_r : wstrb;
  wire [31:0] addrMerged = merge({9'h000, tgtAddr_r}, wrData, wrStrb);
  wire arTake = arvalid && arready;
  wire rdBusy = rvalid && !rready;

  wire ctrlWr = doWrite && wrAddr == fbpc_pkg::REG_CTRL;
  wire [3:0] newOpBits = wrData[fbpc_pkg::CTRL_OP_LSB +: 4];
  wire fbpc_pkg::fbpc_op_t newOp = fbpc_pkg::fbpc_op_t'(newOpBits);
  wire accept = ctrlWr && state_r == ST_IDLE && legal(newOp, mode_r);
  wire refuse = ctrlWr && !accept;
  wire extMode = mode_r == fbpc_pkg::MD_EXT;
  wire [2:0] idx3 = idx_r[2:0];
  wire [fbpc_pkg::STEP_W-1:0] curStep = steps_r[idx3];
  wire cycStart = state_r == ST_ISSUE;
  wire lastStep = idx_r == nSteps_r - 4'h1;
  wire finish = state_r == ST_WAIT && cycDone && lastStep;
  wire isEnter = op_r >= fbpc_pkg::OP_ENT_LOCK && op_r <= fbpc_pkg::OP_ENT_EXT;
  wire [31:0] statusWord = {25'h0000000, mode_r, 2'b00, err_r, state_r != ST_IDLE};
  wire [31:0] rdMux =
    (araddr == fbpc_pkg::REG_ADDR) ? {9'h000, tgtAddr_r} :
    (araddr == fbpc_pkg::REG_PWD_LO) ? pwd_r[31:0] :
    (araddr == fbpc_pkg::REG_PWD_HI) ? pwd_r[63:32] :
    (araddr == fbpc_pkg::REG_STATUS) ? statusWord :
    (araddr == fbpc_pkg::REG_RDATA) ? {16'h0000, rdData_r} :
    (araddr == fbpc_pkg::REG_PRD_LO) ? pwdRead_r[31:0] :
    (araddr == fbpc_pkg::REG_PRD_HI) ? pwdRead_r[63:32] :
    (araddr == fbpc_pkg::REG_WPCTL) ? {31'h00000000, writeProtectN} : 32'h00000000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h00000000;
      wStrb_r <= 4'h0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= 2'b00;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rresp <= 2'b00;
      rdata <= 32'h00000000;
    end else begin
      if (awTake) awAddr_r <= awaddr;
      if (wTake) wData_r <= wdata;
      if (wTake) wStrb_r <= wstrb;
      awHeld_r <= awHave && !doWrite;
      wHeld_r <= wHave && !doWrite;
      awready <= !(awHave && !doWrite);
      wready <= !(wHave && !doWrite);
      bvalid <= doWrite || (bvalid && !bready);
      if (doWrite) bresp <= mapped(wrAddr) ? 2'b00 : 2'b10;
      rvalid <= arTake || rdBusy;
      arready <= !(arTake || rdBusy);
      if (arTake) rdata <= rdMux;
      if (arTake) rresp <= mapped(araddr) ? 2'b00 : 2'b10;
    end
  end

  // Software registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tgtAddr_r <= 23'h000000;
      pwd_r <= fbpc_pkg::PWD_RST;
      writeProtectN <= fbpc_pkg::WPCTL_RST;
      err_r <= 1'b0;
    end else begin
      if (doWrite && wrAddr == fbpc_pkg::REG_ADDR)
        tgtAddr_r <= addrMerged[22:0];
      if (doWrite && wrAddr == fbpc_pkg::REG_PWD_LO)
        pwd_r[31:0] <= merge(pwd_r[31:0], wrData, wrStrb);
      if (doWrite && wrAddr == fbpc_pkg::REG_PWD_HI)
        pwd_r[63:32] <= merge(pwd_r[63:32], wrData, wrStrb);
      // Low level guards the edge blocks of the part
      if (doWrite && wrAddr == fbpc_pkg::REG_WPCTL && wrStrb[0]) writeProtectN <= wrData[0];
      err_r <= refuse || (err_r && !accept);
    end
  end

  // Operation sequencer
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      op_r <= fbpc_pkg::OP_NOP;
      mode_r <= fbpc_pkg::MD_NONE;
      idx_r <= 4'h0;
      nSteps_r <= 4'h1;
      gapCnt_r <= 8'h00;
      rdData_r <= 16'h0000;
      pwdRead_r <= 64'h0000000000000000;
      for (int k = 0; k < fbpc_pkg::MAX_STEPS; k++) steps_r[k] <= {fbpc_pkg::STEP_W{1'b0}};
    end else begin
      case (state_r)
        ST_IDLE: if (accept) begin
          state_r <= ST_ISSUE;
          op_r <= newOp;
          idx_r <= 4'h0;
          nSteps_r <= countOf(newOp, extMode);
          for (int k = 0; k < fbpc_pkg::MAX_STEPS; k++)
            steps_r[k] <= stepOf(newOp, 3'(k), tgtAddr_r,
                                 wrData[fbpc_pkg::CTRL_DATA_LSB +: 16], pwd_r, extMode);
        end
        ST_ISSUE: state_r <= ST_WAIT;
        ST_WAIT: if (cycDone) begin
          if (curStep[fbpc_pkg::STEP_W-1] && op_r == fbpc_pkg::OP_PWD_READ)
            pwdRead_r[16*idx3[1:0] +: 16] <= cycData;
          else if (curStep[fbpc_pkg::STEP_W-1])
            rdData_r <= cycData;
          idx_r <= idx_r + 4'h1;
          state_r <= lastStep ? ST_IDLE : ST_ISSUE;
          if (finish && isEnter) mode_r <= fbpc_pkg::fbpc_mode_t'(op_r[2:0]);
          if (finish && op_r == fbpc_pkg::OP_EXIT) mode_r <= fbpc_pkg::MD_NONE;
          // Hold off after every password unlock: covers the unlock time and the retry spacing
          if (finish && op_r == fbpc_pkg::OP_PWD_UNLOCK) begin
            state_r <= ST_GAP;
            gapCnt_r <= 8'(fbpc_pkg::GUARD_CYC - 1);
          end
        end
        ST_GAP: begin
          gapCnt_r <= gapCnt_r - 8'h01;
          if (gapCnt_r == 8'h00) state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  fbpc_bus_cycle u_cycle (
    .clk(clk),
    .rst(rst),
    .start(cycStart),
    .isRead(curStep[fbpc_pkg::STEP_W-1]),
    .addrIn(curStep[fbpc_pkg::STEP_W-2 -: fbpc_pkg::ADDR_W]),
    .dataIn(curStep[fbpc_pkg::DATA_W-1:0]),
    .done(cycDone),
    .rdData(cycData),
    .flashAddr(flashAddr),
    .flashDqOut(flashDqOut),
    .flashDqIn(flashDqIn),
    .flashDqOe(flashDqOe),
    .chipSelectN(chipSelectN),
    .outputEnableN(outputEnableN),
    .writeEnableN(writeEnableN)
  );

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  enter_lock_code_a: assert property (cycStart && op_r == fbpc_pkg::OP_ENT_LOCK &&
    idx_r == 4'h2 |=> flashDqOut == 16'h0040 && flashDqOe)
    else $error("lock register entry code wrong");
  read_strobe_a: assert property (!outputEnableN |->
    writeEnableN && !flashDqOe && !chipSelectN) else $error("read strobe with write drive");
  pwd_in_mode_a: assert property (state_r != ST_IDLE && op_r inside
    {fbpc_pkg::OP_PWD_PROG, fbpc_pkg::OP_PWD_READ, fbpc_pkg::OP_PWD_UNLOCK} |->
    mode_r == fbpc_pkg::MD_PWD) else $error("password op outside password mode");
  pwd_prog_len_a: assert property (accept && newOp == fbpc_pkg::OP_PWD_PROG |=>
    nSteps_r == 4'h8 && steps_r[7][22:16] == 7'h03)
    else $error("password program not four portions");
  pwd_read_len_a: assert property (accept && newOp == fbpc_pkg::OP_PWD_READ |=>
    nSteps_r == 4'h4 && steps_r[3][39] && steps_r[3][17:16] == 2'h3)
    else $error("password verify not four reads");
  unlock_guard_a: assert property (finish && op_r == fbpc_pkg::OP_PWD_UNLOCK |=>
    state_r == ST_GAP ##249 state_r == ST_GAP ##1 state_r == ST_IDLE)
    else $error("unlock spacing not 1us");
  clear_nv_mode_a: assert property (cycStart && op_r == fbpc_pkg::OP_CLR_NV |->
    mode_r == fbpc_pkg::MD_NV) else $error("clear-all outside nonvolatile mode");
  one_mode_a: assert property (refuse && ctrlWr && state_r == ST_IDLE &&
    mode_r != fbpc_pkg::MD_NONE && newOp == fbpc_pkg::OP_ENT_VOL |=> err_r && $stable(mode_r))
    else $error("second mode entered");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");

  unlock_c: cover property (finish && op_r == fbpc_pkg::OP_PWD_UNLOCK);
  pwd_read_c: cover property (finish && op_r == fbpc_pkg::OP_PWD_READ);
  refuse_c: cover property (refuse);

endmodule

// ===== fbpc_pkg.sv
/*
 * Shared constants and types of the flash block-protection host controller:
 * register map, command codes, bus-cycle timing and step encoding.
 * Assumes a 250 MHz system clock and a flash part wired in 16-bit word mode.
 */
package fbpc_pkg;

  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int STEP_W = 1 + ADDR_W + DATA_W;
  localparam int MAX_STEPS = 8;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_PWD_LO = 8'h08;
  localparam logic [7:0] REG_PWD_HI = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h14;
  localparam logic [7:0] REG_PRD_LO = 8'h18;
  localparam logic [7:0] REG_PRD_HI = 8'h1C;
  localparam logic [7:0] REG_WPCTL = 8'h20;

  // Field positions
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_DATA_LSB = 16;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ERR = 1;
  localparam int STAT_MODE_LSB = 4;

  // Reset values
  localparam logic WPCTL_RST = 1'b1;
  localparam logic [63:0] PWD_RST = 64'hFFFF_FFFF_FFFF_FFFF;

  // Flash bus command cycles
  localparam logic [ADDR_W-1:0] ADDR_UNLK1 = 23'h000555;
  localparam logic [ADDR_W-1:0] ADDR_UNLK2 = 23'h0002AA;
  localparam logic [ADDR_W-1:0] ADDR_ANY = 23'h000000;
  localparam logic [ADDR_W-1:0] PWD_BASE = 23'h000000;
  localparam logic [DATA_W-1:0] CMD_UNLK1 = 16'h00AA;
  localparam logic [DATA_W-1:0] CMD_UNLK2 = 16'h0055;
  localparam logic [DATA_W-1:0] CODE_LOCKREG = 16'h0040;
  localparam logic [DATA_W-1:0] CODE_PWD = 16'h0060;
  localparam logic [DATA_W-1:0] CODE_NV = 16'h00C0;
  localparam logic [DATA_W-1:0] CODE_LKB = 16'h0050;
  localparam logic [DATA_W-1:0] CODE_VOL = 16'h00E0;
  localparam logic [DATA_W-1:0] CODE_EXT = 16'h0088;
  localparam logic [DATA_W-1:0] CODE_EXIT1 = 16'h0090;
  localparam logic [DATA_W-1:0] CODE_EXIT2 = 16'h0000;
  localparam logic [DATA_W-1:0] CODE_PROG = 16'h00A0;
  localparam logic [DATA_W-1:0] CODE_CLR1 = 16'h0080;
  localparam logic [DATA_W-1:0] CODE_CLR2 = 16'h0030;
  localparam logic [DATA_W-1:0] CODE_UNLOCK1 = 16'h0025;
  localparam logic [DATA_W-1:0] CODE_UNLOCK2 = 16'h0003;

  // Timing
  localparam int CLK_MHZ = 250;
  localparam int SETUP_NS = 10;
  localparam int PULSE_NS = 35;
  localparam int HOLD_NS = 10;
  localparam int GUARD_NS = 1000;
  localparam int SETUP_CYC = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_CYC = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int GUARD_CYC = (GUARD_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0, OP_ENT_LOCK = 4'h1, OP_ENT_PWD = 4'h2, OP_ENT_NV = 4'h3,
    OP_ENT_LKB = 4'h4, OP_ENT_VOL = 4'h5, OP_ENT_EXT = 4'h6, OP_EXIT = 4'h7,
    OP_PROG = 4'h8, OP_READ = 4'h9, OP_CLR_NV = 4'hA, OP_PWD_PROG = 4'hB,
    OP_PWD_READ = 4'hC, OP_PWD_UNLOCK = 4'hD
  } fbpc_op_t;

  // Mode codes equal the low bits of the matching enter operation
  typedef enum logic [2:0] {
    MD_NONE = 3'h0, MD_LOCKREG = 3'h1, MD_PWD = 3'h2, MD_NV = 3'h3,
    MD_LKB = 3'h4, MD_VOL = 3'h5, MD_EXT = 3'h6
  } fbpc_mode_t;

endpackage

// ===== fbpc_bus_cycle.sv
/*
 * One asynchronous flash bus cycle, write or read, with setup, strobe and
 * hold phases counted in system clocks. Assumes start only while idle.
 */
module fbpc_bus_cycle (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic isRead,
  input wire logic [fbpc_pkg::ADDR_W-1:0] addrIn,
  input wire logic [fbpc_pkg::DATA_W-1:0] dataIn,
  output logic done,
  output logic [fbpc_pkg::DATA_W-1:0] rdData,
  output logic [fbpc_pkg::ADDR_W-1:0] flashAddr,
  output logic [fbpc_pkg::DATA_W-1:0] flashDqOut,
  input wire logic [fbpc_pkg::DATA_W-1:0] flashDqIn,
  output logic flashDqOe,
  output logic chipSelectN,
  output logic outputEnableN,
  output logic writeEnableN
);

  typedef enum logic [1:0] {
    CY_IDLE = 2'b00, CY_SETUP = 2'b01, CY_PULSE = 2'b10, CY_HOLD = 2'b11
  } fbpc_cyc_t;

  fbpc_cyc_t state_r;
  logic [3:0] cnt_r;
  logic read_r;
  wire cntEnd = (cnt_r == 4'h0);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= CY_IDLE;
      cnt_r <= 4'h0;
      read_r <= 1'b0;
      done <= 1'b0;
      rdData <= 16'h0000;
      flashAddr <= 23'h000000;
      flashDqOut <= 16'h0000;
      flashDqOe <= 1'b0;
      chipSelectN <= 1'b1;
      outputEnableN <= 1'b1;
      writeEnableN <= 1'b1;
    end else begin
      done <= 1'b0;
      cnt_r <= cntEnd ? 4'h0 : cnt_r - 4'h1;
      case (state_r)
        CY_IDLE: if (start) begin
          state_r <= CY_SETUP;
          cnt_r <= 4'(fbpc_pkg::SETUP_CYC - 1);
          read_r <= isRead;
          flashAddr <= addrIn;
          flashDqOut <= dataIn;
          // Data lines stay released during reads so the part can drive them
          flashDqOe <= !isRead;
          chipSelectN <= 1'b0;
        end
        CY_SETUP: if (cntEnd) begin
          state_r <= CY_PULSE;
          cnt_r <= 4'(fbpc_pkg::PULSE_CYC - 1);
          outputEnableN <= !read_r;
          writeEnableN <= read_r;
        end
        CY_PULSE: if (cntEnd) begin
          state_r <= CY_HOLD;
          cnt_r <= 4'(fbpc_pkg::HOLD_CYC - 1);
          rdData <= flashDqIn;
          outputEnableN <= 1'b1;
          writeEnableN <= 1'b1;
        end
        CY_HOLD: if (cntEnd) begin
          state_r <= CY_IDLE;
          chipSelectN <= 1'b1;
          flashDqOe <= 1'b0;
          done <= 1'b1;
        end
        default: state_r <= CY_IDLE;
      endcase
    end
  end

endmodule

// ===== fbpc_flash_model.sv
/* Behavioural x16 flash on the far side of fbpc_host: protection command
   sets, password, lock bit, one volatile bit. Assumes host bus timing. */
module fbpc_flash_model (
  input wire logic [fbpc_pkg::ADDR_W-1:0] flashAddr,
  input wire logic [fbpc_pkg::DATA_W-1:0] flashDqOut,
  input wire logic chipSelectN,
  input wire logic outputEnableN,
  input wire logic writeEnableN,
  output logic [fbpc_pkg::DATA_W-1:0] flashDqIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] mode = 3'h0;
  logic [15:0] pwd [4] = '{default: 16'hFFFF};
  logic [15:0] lockReg = 16'hFFFF;
  logic lkb = 1'b0;
  logic vol = 1'b1;
  logic nvb = 1'b1;
  logic clr = 1'b0;
  logic [15:0] extW = 16'hFFFF;
  wire logic blkLocked = !nvb || !vol;
  logic [1:0] seq = 2'h0;
  logic [1:0] u = 2'h0;
  logic pend = 1'b0;
  logic ex = 1'b0;
  logic ok;
  logic [2:0] k;
  logic [15:0] rdv;
  logic [15:0] lastQ = 16'h0000;
  wire logic [7:0] d = flashDqOut[7:0];
  wire logic [1:0] w = flashAddr[1:0];
  always @(posedge writeEnableN) if (!chipSelectN) begin
    if (pend) begin
      pend = 1'b0;
      case (mode)
        3'h1: lockReg = flashDqOut;
        3'h2: pwd[w] = flashDqOut;
        3'h3: nvb = flashDqOut[0];
        // Bits only fall, and a cleared lock register bit 0 freezes the block
        3'h6: if (lockReg[0]) extW = extW & flashDqOut;
        3'h4: lkb = 1'b0;
        3'h5: vol = flashDqOut[0];
        default: ;
      endcase
    end else if (u == 2'h2) begin
      ok = ok && (flashDqOut === pwd[w]);
      k = k + 3'h1;
      if (k == 3'h4) u = 2'h0;
      if (k == 3'h4 && ok) lkb = 1'b1;
    end else if (u == 2'h1) begin
      u = (d == 8'h03) ? 2'h2 : 2'h0;
      k = 3'h0;
      ok = 1'b1;
    end else if (mode == 3'h2 && d == 8'h25) u = 2'h1;
    else if (clr) begin
      clr = 1'b0;
      if (d == 8'h30 && lkb) nvb = 1'b1;
    end else if (mode == 3'h3 && d == 8'h80) clr = 1'b1;
    else if (d == 8'h90) begin
      ex = 1'b1;
      seq = 2'h0;
    end else if (ex) begin
      ex = 1'b0;
      if (d == 8'h00) mode = 3'h0;
    end else if (d == 8'hA0 && mode != 3'h0) pend = 1'b1;
    else if (d == 8'hAA) seq = 2'h1;
    else if (seq == 2'h1 && d == 8'h55) seq = 2'h2;
    else if (seq == 2'h2 && mode == 3'h0) begin
      seq = 2'h0;
      mode = (d == 8'h40) ? 3'h1 : (d == 8'h60) ? 3'h2 : (d == 8'hC0) ? 3'h3 :
        (d == 8'h50) ? 3'h4 : (d == 8'hE0) ? 3'h5 : (d == 8'h88) ? 3'h6 : 3'h0;
    end
  end
  always_comb begin
    case (mode)
      3'h1: rdv = lockReg;
      3'h2: rdv = pwd[w];
      3'h3: rdv = {15'h0000, nvb};
      3'h4: rdv = {15'h0000, lkb};
      3'h6: rdv = extW;
      3'h5: rdv = {15'h0000, vol};
      default: rdv = flashAddr[15:0] ^ 16'h5A5A;
    endcase
  end
  // Released bus shows the inverse, so a stale sample never looks right
  always @(posedge outputEnableN) lastQ <= rdv;
  assign flashDqIn = (!chipSelectN && !outputEnableN) ? rdv : ~lastQ;
endmodule

// ===== test_fbpc_host.sv
/* Self-checking bench for fbpc_host over AXI4-Lite with a flash model.
   Assumes the register map and op codes of fbpc_pkg. */
module test_fbpc_host;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid;
  logic arready, rvalid, flashDqOe, chipSelectN, outputEnableN, writeEnableN, writeProtectN;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  logic [22:0] flashAddr;
  logic [15:0] flashDqOut, flashDqIn;
  int n_errors = 0, samples_checked = 0, cyc = 0, t;
  fbpc_host uut (.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .flashAddr, .flashDqOut, .flashDqIn, .flashDqOe, .chipSelectN, .outputEnableN,
    .writeEnableN, .writeProtectN);
  fbpc_flash_model flash (.flashAddr, .flashDqOut, .chipSelectN, .outputEnableN,
    .writeEnableN, .flashDqIn);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("FAIL t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    r = rresp;
  endtask
  task automatic op(input logic [3:0] o, input logic [15:0] d = 16'h0000);
    int t0;
    t0 = cyc;
    wr(fbpc_pkg::REG_CTRL, {d, 12'h000, o});
    do rd(fbpc_pkg::REG_STATUS); while (v[0] !== 1'b0);
    t = cyc - t0;
  endtask
  initial begin
    // Response ready stays high, so every answer is taken at its first edge
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h25;
    {awaddr, araddr, wdata, wstrb} = {16'h0000, 32'h00000000, 4'hF};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(fbpc_pkg::REG_PWD_LO);
    chk(v, 32'hFFFFFFFF);
    rd(fbpc_pkg::REG_WPCTL);
    chk(v, 32'h00000001);
    rd(8'h24);
    chk(32'(r), 32'h00000002);
    wr(8'h24, 32'h00000000);
    chk(32'(r), 32'h00000002);
    $display("test registers done");
    for (int m = 1; m < 6; m++) begin
      op(4'(m));
      chk(32'(v[6:4]), 32'(m));
      op(fbpc_pkg::OP_EXIT);
      chk(32'(v[6:4]), 32'h00000000);
    end
    op(fbpc_pkg::OP_ENT_LOCK);
    op(fbpc_pkg::OP_ENT_VOL);
    chk(32'({v[6:4], v[1]}), 32'h00000003);
    wr(fbpc_pkg::REG_ADDR, 32'h00000000);
    op(fbpc_pkg::OP_PROG, 16'h1234);
    op(fbpc_pkg::OP_READ);
    rd(fbpc_pkg::REG_RDATA);
    chk(32'(v[15:0]), 32'h00001234);
    op(fbpc_pkg::OP_EXIT);
    op(fbpc_pkg::OP_PWD_PROG);
    chk(32'(v[1]), 32'h00000001);
    $display("test modes done");
    op(fbpc_pkg::OP_ENT_PWD);
    wr(fbpc_pkg::REG_PWD_LO, 32'h89ABCDEF);
    wr(fbpc_pkg::REG_PWD_HI, 32'h01234567);
    op(fbpc_pkg::OP_PWD_PROG);
    op(fbpc_pkg::OP_PWD_READ);
    rd(fbpc_pkg::REG_PRD_LO);
    chk(v, 32'h89ABCDEF);
    rd(fbpc_pkg::REG_PRD_HI);
    chk(v, 32'h01234567);
    op(fbpc_pkg::OP_PWD_UNLOCK);
    chk(32'(flash.lkb), 32'h00000001);
    chk(32'(t > fbpc_pkg::GUARD_CYC), 32'h00000001);
    op(fbpc_pkg::OP_EXIT);
    op(fbpc_pkg::OP_ENT_LKB);
    op(fbpc_pkg::OP_PROG);
    op(fbpc_pkg::OP_READ);
    rd(fbpc_pkg::REG_RDATA);
    chk(32'(v[15:0]), 32'h00000000);
    op(fbpc_pkg::OP_EXIT);
    op(fbpc_pkg::OP_ENT_PWD);
    wr(fbpc_pkg::REG_PWD_HI, 32'h01234566);
    op(fbpc_pkg::OP_PWD_UNLOCK);
    chk(32'(flash.lkb), 32'h00000000);
    op(fbpc_pkg::OP_EXIT);
    op(fbpc_pkg::OP_ENT_NV);
    op(fbpc_pkg::OP_PROG);
    op(fbpc_pkg::OP_CLR_NV);
    op(fbpc_pkg::OP_READ);
    rd(fbpc_pkg::REG_RDATA);
    chk(32'(v[15:0]), 32'h00000000);
    op(fbpc_pkg::OP_EXIT);
    $display("test password done");
    op(fbpc_pkg::OP_ENT_VOL);
    wr(fbpc_pkg::REG_ADDR, 32'h00010000);
    for (int b = 0; b < 2; b++) begin
      op(fbpc_pkg::OP_PROG, 16'(b));
      op(fbpc_pkg::OP_READ);
      rd(fbpc_pkg::REG_RDATA);
      chk(32'(v[15:0]), 32'(b));
    end
    chk(32'(flash.blkLocked), 32'h00000001);
    op(fbpc_pkg::OP_EXIT);
    op(fbpc_pkg::OP_ENT_EXT);
    chk(32'(v[6:4]), 32'(fbpc_pkg::MD_EXT));
    op(fbpc_pkg::OP_PROG, 16'h00AA);
    op(fbpc_pkg::OP_READ);
    rd(fbpc_pkg::REG_RDATA);
    chk(32'(v[15:0]), 32'h0000FFFF);
    op(fbpc_pkg::OP_EXIT);
    chk(32'(v[6:4]), 32'h00000000);
    wr(fbpc_pkg::REG_WPCTL, 32'h00000000);
    rd(fbpc_pkg::REG_WPCTL);
    chk(32'(writeProtectN), 32'h00000000);
    $display("test volatile extended pin done");
    report_and_stop;
  end
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    $display("FAIL t=%0t watchdog expired", $time);
    report_and_stop;
  end
endmodule
